/* sim/counter_array_module_mode_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "counter_array_regs.svh"
module counter_array_module_mode_tb;
  import counter_array_pkg::*;
  sfr_req_t sfr = '0;
  logic [7:0] rdata;
  logic ref_clk_in, rstn_in = 1'b0, tick = 1'b0, lock = 1'b0, watch = 1'b0;
  logic [1:0] cls = 2'b00;
  logic [5:0] clr = 6'h00, level = 6'h00, cap, flags, irq, pins;
  int high_count, err_count = 0, samples_checked = 0;
  logic [7:0] ccl_a [5] = '{`CCL0_ADDR, `CCL1_ADDR, `CCL2_ADDR, `CCL3_ADDR, `CCL4_ADDR};
  logic [7:0] cmp_mode [5] = '{8'h49, 8'h48, 8'h08, 8'h44, 8'hc4};
  counter_array_module_mode counter_array_module_mode_inst (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sfr_in(sfr), .sfr_rdata_out(rdata),
    .count_tick_in(tick), .watchdog_lock_enable_in(lock), .cycle_length_select_in(cls),
    .capture_pin_in(cap), .compare_event_flag_clr_in(clr), .compare_event_flag_out(flags),
    .module_irq_out(irq), .module_output_pin_out(pins));
  pin_partner pin_partner_inst (.ref_clk_in(ref_clk_in), .level_in(level), .watch_in(watch),
    .pin_in(pins[0]), .capture_pin_out(cap), .high_count_out(high_count));
  // 100 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Duty counts allow a couple of cycles of pipeline slack
  task automatic chk_cnt(input int got, input int exp);
    samples_checked++;
    if (got < exp - 2 || got > exp + 2) begin
      err_count++;
      $display("[ERR] %0t high count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge ref_clk_in);
    #1;
  endtask
  // One strobe cycle then one idle cycle, so no signal is driven twice at once
  task automatic sfr_go(input logic [7:0] a, input logic [7:0] d, input logic w);
    sfr = '{addr: a, wdata: d, wr: w, rd: !w};
    step();
    sfr = '0;
    step();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_go(a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_go(a, 8'h00, 1'b0);
    chk8(rdata, exp);
  endtask
  task automatic run(input int n);
    tick = 1'b1;
    repeat (n) step();
    tick = 1'b0;
  endtask
  task automatic set_cnt(input logic [15:0] v);
    wr(`CNT_LOW_ADDR, v[7:0]);
    wr(`CNT_HIGH_ADDR, v[15:8]);
  endtask
  // Compare value first, since writing it clears the comparator enable
  task automatic pwm_chk(input logic [7:0] m, input logic [1:0] c, input logic [15:0] cc,
      input logic [15:0] start, input int settle, input int win, input int exp);
    cls = c;
    wr(`CCL0_ADDR, cc[7:0]);
    wr(`CCH0_ADDR, cc[15:8]);
    wr(`MODE0_ADDR, m);
    set_cnt(start);
    // Tick stays high across settle and window, so it is never driven twice in one step
    tick = 1'b1;
    repeat (settle) step();
    watch = 1'b1;
    repeat (win) step();
    watch = 1'b0;
    tick = 1'b0;
    chk_cnt(high_count, exp);
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well past the expected run of about 25k cycles
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    err_count++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge ref_clk_in);
    #1;
    rstn_in = 1'b1;
    // Reset values, counter bytes and the high-byte snapshot
    rd(`MODE0_ADDR, `MODE_RESET);
    rd(`CNT_LOW_ADDR, 8'h00);
    set_cnt(16'h1237);
    rd(`CNT_LOW_ADDR, 8'h37);
    wr(`CNT_HIGH_ADDR, 8'h34);
    rd(`CNT_HIGH_ADDR, 8'h12);
    rd(`CNT_LOW_ADDR, 8'h37);
    rd(`CNT_HIGH_ADDR, 8'h34);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    $display("registers done");
    // Match flags, masking, toggling and the wide bit outside PWM
    for (int i = 0; i < 5; i++) begin
      wr(ccl_a[i], 8'h05);
      wr(`MODE0_ADDR + 8'(i), cmp_mode[i]);
    end
    // High byte differs, so module 4 only toggles if its wide bit is ignored
    wr(`CCH4_ADDR, 8'h01);
    set_cnt(16'h0000);
    run(10);
    chk8({2'b00, flags}, 8'h03);
    chk8({2'b00, irq}, 8'h01);
    chk8({2'b00, pins}, 8'h18);
    clr = 6'h3f;
    step();
    clr = 6'h00;
    chk8({2'b00, flags}, 8'h00);
    wr(`CCL0_ADDR, 8'h05);
    rd(`MODE0_ADDR, 8'h09);
    $display("compare done");
    // Capture on the chosen edge only
    wr(`MODE5_ADDR, 8'h20);
    set_cnt(16'h1234);
    level = 6'h20;
    repeat (6) step();
    rd(`CCL5_ADDR, 8'h34);
    rd(`CCH5_ADDR, 8'h12);
    chk8({2'b00, flags}, 8'h20);
    wr(`MODE5_ADDR, 8'h10);
    set_cnt(16'h0056);
    level = 6'h00;
    repeat (6) step();
    rd(`CCL5_ADDR, 8'h56);
    set_cnt(16'h0099);
    level = 6'h20;
    repeat (6) step();
    rd(`CCL5_ADDR, 8'h56);
    $display("capture done");
    // Lock freezes module 5 mode and the counter low byte
    lock = 1'b1;
    wr(`MODE5_ADDR, 8'hff);
    wr(`CNT_LOW_ADDR, 8'h5a);
    rd(`MODE5_ADDR, 8'h10);
    rd(`CNT_LOW_ADDR, 8'h99);
    lock = 1'b0;
    wr(`MODE5_ADDR, 8'h00);
    rd(`MODE5_ADDR, 8'h00);
    $display("lock done");
    // Every cycle length, then 16-bit PWM across a wrap, then frequency output
    for (int n = 0; n < 4; n++) begin
      pwm_chk(8'h42, 2'(n), 16'h0040, 16'h0000, 256 << n, 256 << n, (256 << n) - 64);
    end
    pwm_chk(8'hc2, 2'b00, 16'hc040, 16'hc000, 72, 16568, 16312);
    pwm_chk(8'h46, 2'b00, 16'h0040, 16'h0000, 256, 512, 256);
    $display("pwm done");
    close_out();
  end
endmodule
`default_nettype wire

/* sim/pin_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  input wire logic ref_clk_in, // Sampling clock
  input wire logic [5:0] level_in, // Wanted capture pin levels
  input wire logic watch_in, // Count high cycles while set
  input wire logic pin_in, // Output pin under watch
  output logic [5:0] capture_pin_out, // Pins into the block
  output int high_count_out // High cycles seen
);
  // Pins move off the clock edge, as a real async source would
  initial capture_pin_out = 6'h00;
  always @(level_in) capture_pin_out <= #3 level_in;
  // Duty counter, cleared whenever not watching
  always @(posedge ref_clk_in) begin
    if (!watch_in) high_count_out <= 0;
    else if (pin_in) high_count_out <= high_count_out + 1;
  end
endmodule
`default_nettype wire

/* verilog/counter_array_module_mode.sv */
// Behaviour
// - Wide select picks 16-bit or 8-11-bit PWM
// - Comparator enable turns on value comparison
// - Rising input edge captures counter value
// - Falling input edge captures counter value
// - Match sets compare event flag
// - Toggle enable inverts output on match
// - Toggle plus PWM means frequency output
// - PWM enable drives modulated output pin
// - Irq enable masks compare event flag
// - Watchdog lock blocks module 5 mode writes; a CCL5 write still clears its comparator enable
// - Low byte exposes counter bits 7-0
// - Watchdog lock blocks counter low writes
// - High byte read returns low-read snapshot
// - Cycle select gives 8 to 11 bits
// - Compare low write clears comparator enable
`timescale 1ns/10ps
`default_nettype none
`include "counter_array_regs.svh"
module counter_array_module_mode
  import counter_array_pkg::*;
(
  input wire logic ref_clk_in, // System clock
  input wire logic rstn_in, // Synchronous reset, active low
  input wire sfr_req_t sfr_in, // Register bus request
  output logic [7:0] sfr_rdata_out, // Read data, registered
  input wire logic count_tick_in, // Counter advance strobe, same clock
  input wire logic watchdog_lock_enable_in, // Blocks module 5 mode writes and both counter byte writes
  input wire logic [1:0] cycle_length_select_in, // PWM cycle length
  input wire logic [5:0] capture_pin_in, // Async capture inputs
  input wire logic [5:0] compare_event_flag_clr_in, // Flag clear pulses
  output logic [5:0] compare_event_flag_out, // Sticky match/capture flags
  output logic [5:0] module_irq_out, // Masked interrupt requests
  output logic [5:0] module_output_pin_out // Module output levels
);
  logic [15:0] cnt_q;
  logic [7:0] snap_q;
  module_mode_t mode_q [0:5];
  logic [15:0] cc_q [0:5];
  logic [5:0] out_q;
  logic [5:0] flag_q;
  logic [7:0] rdata_d;
  logic [7:0] mode_addr [0:5];
  logic [7:0] ccl_addr [0:5];
  logic [7:0] cch_addr [0:5];
  logic [5:0] s1_q, s2_q, s3_q;
  logic [5:0] pin_lvl_q;

  assign mode_addr = '{`MODE0_ADDR, `MODE1_ADDR, `MODE2_ADDR,
                       `MODE3_ADDR, `MODE4_ADDR, `MODE5_ADDR};
  assign ccl_addr = '{`CCL0_ADDR, `CCL1_ADDR, `CCL2_ADDR,
                      `CCL3_ADDR, `CCL4_ADDR, `CCL5_ADDR};
  assign cch_addr = '{`CCH0_ADDR, `CCH1_ADDR, `CCH2_ADDR,
                      `CCH3_ADDR, `CCH4_ADDR, `CCH5_ADDR};

  // Counter write decode; the lock keeps software off the watchdog's count
  wire cnt_lo_wr = sfr_in.wr && sfr_in.addr == `CNT_LOW_ADDR
                   && !watchdog_lock_enable_in;
  wire cnt_hi_wr = sfr_in.wr && sfr_in.addr == `CNT_HIGH_ADDR
                   && !watchdog_lock_enable_in;
  wire cnt_lo_rd = sfr_in.rd && sfr_in.addr == `CNT_LOW_ADDR;

  // Cycle wrap bit chosen by cycle select for the narrow modes
  wire [15:0] cnt_next = cnt_q + 16'h0001;
  logic [3:0] wrap_bit;
  assign wrap_bit = 4'h7 + {2'b00, cycle_length_select_in};
  wire [15:0] low_mask = (16'h0001 << (wrap_bit + 4'h1)) - 16'h0001;

  // Shared counter and high-byte snapshot
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cnt_q <= `CNT_RESET;
      snap_q <= 8'h00;
    end else begin
      if (cnt_lo_wr) cnt_q[7:0] <= sfr_in.wdata;
      else if (cnt_hi_wr) cnt_q[15:8] <= sfr_in.wdata;
      else if (count_tick_in) cnt_q <= cnt_next;
      if (cnt_lo_rd) snap_q <= cnt_q[15:8];
    end
  end

  // Pin synchroniser: three stages; a level counts once stages two and three agree,
  // so a pin caught mid-change never gives a false edge
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
      pin_lvl_q <= 6'h00;
    end else begin
      s1_q <= capture_pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  // Accepted pin level follows stage three only while stages two and three agree
  wire [5:0] pin_agree = ~(s2_q ^ s3_q);
  wire [5:0] pin_lvl_d = (pin_agree & s3_q) | (~pin_agree & pin_lvl_q);

  genvar i;
  generate
    for (i = 0; i < `NUM_MODULES; i = i + 1) begin : g_mod
      module_mode_t m;
      assign m = mode_q[i];
      wire locked = (i == `WDOG_MODULE) && watchdog_lock_enable_in;
      wire mode_wr = sfr_in.wr && sfr_in.addr == mode_addr[i] && !locked;
      wire ccl_wr = sfr_in.wr && sfr_in.addr == ccl_addr[i];
      wire cch_wr = sfr_in.wr && sfr_in.addr == cch_addr[i];
      wire rise = pin_agree[i] && s3_q[i] && !pin_lvl_q[i];
      wire fall = pin_agree[i] && !s3_q[i] && pin_lvl_q[i];
      wire cap = (m.rising_capture_enable && rise)
                 || (m.falling_capture_enable && fall);
      // Wide select only matters while PWM enable is set, in PWM and frequency output
      wire wide = m.pulse_width_enable && m.wide_mode_select;
      wire [15:0] cmp_mask = wide ? 16'hffff : low_mask;
      wire eq = m.comparator_enable && count_tick_in
                && ((cnt_q & cmp_mask) == (cc_q[i] & cmp_mask));
      wire wrap = count_tick_in && ((cnt_q & cmp_mask) == cmp_mask);
      out_mode_t om;
      assign om = (m.toggle_enable && m.pulse_width_enable) ? OUT_FREQ
                : m.pulse_width_enable ? OUT_PWM
                : m.toggle_enable ? OUT_TOGGLE : OUT_IDLE;
      wire set_flag = (eq && m.match_flag_enable) || cap;

      // Mode, compare value, flag and output pin per module
      always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
          mode_q[i] <= `MODE_RESET;
          cc_q[i] <= 16'h0000;
          flag_q[i] <= 1'b0;
          out_q[i] <= 1'b0;
        end else begin
          if (mode_wr) mode_q[i] <= sfr_in.wdata;
          else if (ccl_wr) mode_q[i].comparator_enable <= 1'b0;
          if (cap) cc_q[i] <= cnt_q;
          else if (ccl_wr) cc_q[i][7:0] <= sfr_in.wdata;
          else if (cch_wr) cc_q[i][15:8] <= sfr_in.wdata;
          // Set wins over a simultaneous clear
          if (set_flag) flag_q[i] <= 1'b1;
          else if (compare_event_flag_clr_in[i]) flag_q[i] <= 1'b0;
          case (om)
            OUT_TOGGLE, OUT_FREQ: if (eq) out_q[i] <= ~out_q[i];
            OUT_PWM: begin
              if (eq) out_q[i] <= 1'b1;
              else if (wrap) out_q[i] <= 1'b0;
            end
            default: out_q[i] <= out_q[i];
          endcase
        end
      end
      assign module_irq_out[i] = flag_q[i] && m.compare_irq_enable;
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (sfr_in.addr == `CNT_LOW_ADDR) rdata_d = cnt_q[7:0];
    if (sfr_in.addr == `CNT_HIGH_ADDR) rdata_d = snap_q;
    for (int k = 0; k < `NUM_MODULES; k++) begin
      if (sfr_in.addr == mode_addr[k]) rdata_d = mode_q[k];
      if (sfr_in.addr == ccl_addr[k]) rdata_d = cc_q[k][7:0];
      if (sfr_in.addr == cch_addr[k]) rdata_d = cc_q[k][15:8];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) sfr_rdata_out <= 8'h00;
    else if (sfr_in.rd) sfr_rdata_out <= rdata_d;
  end

  assign compare_event_flag_out = flag_q;
  assign module_output_pin_out = out_q;

  // Checks
  property p_lock_mode;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (watchdog_lock_enable_in && sfr_in.wr && sfr_in.addr == `MODE5_ADDR)
      |=> $stable(mode_q[5]);
  endproperty
  a_lock_mode: assert property (p_lock_mode) else $error("module 5 mode changed");
  property p_lock_cnt;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (watchdog_lock_enable_in && sfr_in.wr && sfr_in.addr == `CNT_LOW_ADDR
       && !count_tick_in) |=> $stable(cnt_q);
  endproperty
  a_lock_cnt: assert property (p_lock_cnt) else $error("locked counter written");
  property p_low_wr;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (!watchdog_lock_enable_in && sfr_in.wr && sfr_in.addr == `CNT_LOW_ADDR)
      |=> cnt_q[7:0] == $past(sfr_in.wdata);
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("low byte write lost");
  property p_snap;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (sfr_in.rd && sfr_in.addr == `CNT_LOW_ADDR) |=> snap_q == $past(cnt_q[15:8]);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot wrong");
  property p_snap_hold;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      !(sfr_in.rd && sfr_in.addr == `CNT_LOW_ADDR) |=> $stable(snap_q);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved");
  property p_ccl_clr;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (sfr_in.wr && sfr_in.addr == `CCL0_ADDR) |=> !mode_q[0].comparator_enable;
  endproperty
  a_ccl_clr: assert property (p_ccl_clr) else $error("comparator not cleared");
  property p_irq;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      module_irq_out[0] == (flag_q[0] && mode_q[0].compare_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mask wrong");
  property p_match;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (g_mod[0].eq && mode_q[0].match_flag_enable) |=> flag_q[0];
  endproperty
  a_match: assert property (p_match) else $error("match flag not set");
  property p_toggle;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (g_mod[0].eq && mode_q[0].toggle_enable) |=> out_q[0] != $past(out_q[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output not toggled");
  property p_cap;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      g_mod[5].cap |=> cc_q[5] == $past(cnt_q);
  endproperty
  a_cap: assert property (p_cap) else $error("capture wrong");
  c_cap: cover property (@(posedge ref_clk_in) g_mod[5].cap);
  c_pwm: cover property (@(posedge ref_clk_in) g_mod[0].om == OUT_PWM && g_mod[0].eq);
  c_freq: cover property (@(posedge ref_clk_in) g_mod[0].om == OUT_FREQ && g_mod[0].eq);
endmodule
`default_nettype wire

/* verilog/counter_array_pkg.sv */
`default_nettype none
package counter_array_pkg;
  // Mode register layout, high bit first
  typedef struct packed {
    logic wide_mode_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pulse_width_enable;
    logic compare_irq_enable;
  } module_mode_t;
  // Special-function bus access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_req_t;
  typedef enum logic [1:0] {
    OUT_IDLE, OUT_TOGGLE, OUT_FREQ, OUT_PWM
  } out_mode_t;
endpackage
`default_nettype wire

/* verilog/counter_array_regs.svh */
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH
// Special-function addresses
`define CNT_LOW_ADDR 8'hf9
`define CNT_HIGH_ADDR 8'hfa
`define MODE0_ADDR 8'hda
`define MODE1_ADDR 8'hdb
`define MODE2_ADDR 8'hdc
`define MODE3_ADDR 8'hdd
`define MODE4_ADDR 8'hde
`define MODE5_ADDR 8'hce
`define CCL0_ADDR 8'hfb
`define CCL1_ADDR 8'he9
`define CCL2_ADDR 8'heb
`define CCL3_ADDR 8'hed
`define CCL4_ADDR 8'hfd
`define CCL5_ADDR 8'hd2
`define CCH0_ADDR 8'hfc
`define CCH1_ADDR 8'hea
`define CCH2_ADDR 8'hec
`define CCH3_ADDR 8'hee
`define CCH4_ADDR 8'hfe
`define CCH5_ADDR 8'hd3
// Mode register field positions
`define MODE_WIDE_BIT 7
`define MODE_CMP_BIT 6
`define MODE_RISE_BIT 5
`define MODE_FALL_BIT 4
`define MODE_MATCH_BIT 3
`define MODE_TOG_BIT 2
`define MODE_PWM_BIT 1
`define MODE_IRQ_BIT 0
// Reset values, module count and watchdog module
`define MODE_RESET 8'h00
`define CNT_RESET 16'h0000
`define NUM_MODULES 6
`define WDOG_MODULE 5
`endif
